// [include/lsf_crc_if.sv]
// interface: crc engine request and result between main block and crc walker
`timescale 1ns/1ps
interface lsf_crc_if;
   logic       start; // pulse: begin a new pass over memory
   logic [7:0] addr;  // memory word being read
   logic [7:0] data;  // word returned for addr
   logic       done;  // pulse: result valid
   logic [7:0] crc;   // crc of the full pass
   modport main (output start, output data, input addr, input done, input crc);
   modport eng  (input start, input data, output addr, output done, output crc);
endinterface : lsf_crc_if

// [include/lsf_pkg.sv]
// package: offsets, field layout, reset values, timing and states of the status block
package lsf_pkg;
   // ==========================================
   // register map
   localparam logic [7:0] LSF_OFS_SHORT3 = 8'hae; // short flags, groups g and h
   localparam logic [7:0] LSF_OFS_CRC    = 8'haf; // config memory crc result
   localparam logic [7:0] LSF_RST_SHORT3 = 8'h00; // reset value of short flags
   localparam logic [7:0] LSF_RST_CRC    = 8'h00; // reset value of crc result
   // ==========================================
   // field positions in the short flag register
   localparam int LSF_BIT_G0 = 0;
   localparam int LSF_BIT_G2 = 2;
   localparam int LSF_BIT_H0 = 4;
   localparam int LSF_BIT_H2 = 6;
   localparam logic [7:0] LSF_RSVD_MASK = 8'h88; // bits 7 and 3 read zero
   // ==========================================
   // crc and memory
   localparam int              LSF_MEM_WORDS = 256;   // config memory depth
   localparam logic [7:0]      LSF_CRC_POLY  = 8'h07; // x^8+x^2+x+1
   localparam logic [7:0]      LSF_CRC_INIT  = 8'hff; // crc seed
   // ==========================================
   // host watchdog: 100 us loss of traffic enters fail-safe
   localparam int LSF_WDOG_US     = 100;
   localparam int LSF_CLK_MHZ     = 20;
   localparam int LSF_WDOG_CYCLES = LSF_WDOG_US * LSF_CLK_MHZ; // longest time, exact
   // ==========================================
   // operating states, gray along normal path
   typedef enum logic [1:0] {
      LSF_ST_INIT   = 2'b00,
      LSF_ST_NORMAL = 2'b01,
      LSF_ST_SAFE   = 2'b11
   } lsf_state_e;
endpackage : lsf_pkg

// [verification/lsf_host_model.sv]
// partner: host controller issuing accesses and frames
`timescale 1ns/1ps
module lsf_host_model (
   input  wire logic       clk,          // bench clock
   input  wire logic       req,          // read wanted
   input  wire logic       wr,           // write wanted
   input  wire logic [7:0] req_addr,     // offset to use
   input  wire logic       ping,         // send a frame
   output logic            reg_rd,       // to device
   output logic            reg_wr,       // to device
   output logic      [7:0] reg_addr,     // to device
   output logic            host_activity // to device
);
   logic [7:0] idle_r = 8'h5a; // moving address while idle
   always_ff @(negedge clk) begin
      idle_r <= idle_r + 8'h35;
   end
   // address never parks between accesses, so stale values cannot pass
   always_comb begin
      reg_rd        = req;
      reg_wr        = wr;
      reg_addr      = (req | wr) ? req_addr : idle_r;
      host_activity = ping;
   end
endmodule : lsf_host_model

// [verification/lsf_status_props.sv]
// checker: port-level relations of the status block
`timescale 1ns/1ps
module lsf_status_props
   import lsf_pkg::*;
(
   input wire logic       clk,           // clock
   input wire logic       reset,         // sync reset
   input wire logic [2:0] short_in_g,    // detectors g
   input wire logic [2:0] short_in_h,    // detectors h
   input wire logic       host_activity, // host frame
   input wire logic       reg_rd,        // read strobe
   input wire logic       reg_wr,        // write strobe
   input wire logic [7:0] reg_addr,      // offset
   input wire logic [7:0] reg_rdata,     // read data
   input wire logic       reg_rvalid,    // read valid
   input wire logic       fail_safe,     // fail-safe level
   input wire logic       outputs_on     // outputs driven
);
   // ==========================================
   // cycles since the last host frame
   int idle_r;   // idle count
   int idle_nxt; // next idle count
   always_comb begin
      idle_nxt = host_activity ? 0 : idle_r + 1;
   end
   always_ff @(posedge clk) begin
      idle_r <= reset ? 0 : idle_nxt;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ==========================================
   // flags need four steady samples, so a mid-sync change is never judged
   a_h_flags_map: assert property (reg_rd && reg_addr == LSF_OFS_SHORT3
      && $stable(short_in_h) && short_in_h == $past(short_in_h, 2)
      && short_in_h == $past(short_in_h, 3) |=> reg_rdata[6:4] == $past(short_in_h))
      else $error("h flags differ from detectors");
   a_g_flags_map: assert property (reg_rd && reg_addr == LSF_OFS_SHORT3
      && $stable(short_in_g) && short_in_g == $past(short_in_g, 2)
      && short_in_g == $past(short_in_g, 3) |=> reg_rdata[2:0] == $past(short_in_g))
      else $error("g flags differ from detectors");
   a_rsvd_bits_zero: assert property (reg_rd && reg_addr == LSF_OFS_SHORT3
      |=> reg_rvalid && (reg_rdata & LSF_RSVD_MASK) == 8'h00)
      else $error("reserved short bits set");
   a_write_silent: assert property (reg_wr && !reg_rd |=> !reg_rvalid)
      else $error("write produced a response");
   a_reset_zero: assert property ($fell(reset) |-> reg_rdata == 8'h00)
      else $error("read data not zero after reset");
   a_safe_keeps_on: assert property (fail_safe |-> outputs_on)
      else $error("fail-safe without outputs");
   a_wdog_entry: assert property (idle_r > 2003 |-> fail_safe)
      else $error("no fail-safe after host silence");
   a_no_host_safe: assert property ($fell(reset) && !host_activity
      ##1 !host_activity |=> fail_safe && outputs_on)
      else $error("standalone start not in fail-safe");
endmodule : lsf_status_props

bind lsf_status lsf_status_props u_props (.clk, .reset, .short_in_g, .short_in_h,
   .host_activity, .reg_rd, .reg_wr, .reg_addr, .reg_rdata, .reg_rvalid, .fail_safe,
   .outputs_on);

// [verification/lsf_status_tb.sv]
// testbench: short flags, crc result and fail-safe of the status block
`timescale 1ns/1ps
module lsf_status_tb;
   import lsf_pkg::*;
   logic       clk = 0, reset = 1, cfg_wr = 0, req = 0, wr = 0, ping = 0; // drives
   logic [2:0] short_in_g = 0, short_in_h = 0;                    // detectors
   logic [7:0] cfg_addr = 0, cfg_wdata = 0, reg_wdata = 0, req_addr = 0; // buses
   logic       reg_rd, reg_wr, host_activity, reg_rvalid, fail_safe, outputs_on; // nets
   logic [7:0] reg_addr, reg_rdata, d;                             // read path
   logic [7:0] mem [256];                                          // memory shadow
   logic [31:0] seed = 32'd82;                                     // xorshift state
   int         bad_count = 0, tests_run = 0, i, n;                 // counters

   always #25 clk = ~clk;

   lsf_status dut (.clk, .reset, .short_in_g, .short_in_h, .host_activity, .cfg_wr,
      .cfg_addr, .cfg_wdata, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid, .fail_safe, .outputs_on);
   lsf_host_model host (.clk, .req, .wr, .req_addr, .ping, .reg_rd, .reg_wr,
      .reg_addr, .host_activity);

   function logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : rnd

   // crc-8 msb first over the shadow, no final inversion
   function logic [7:0] crc_exp();
      logic [7:0] c;
      c = LSF_CRC_INIT;
      for (int a = 0; a < LSF_MEM_WORDS; a++) begin
         c = c ^ mem[a];
         for (int b = 0; b < 8; b++) c = c[7] ? ((c << 1) ^ LSF_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc_exp

   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // answer is registered on the taking edge and sampled half a cycle later
   task rd(input logic [7:0] a);
      req <= 1'b1;
      req_addr <= a;
      @(negedge clk);
      req <= 1'b0;
      chk({7'h00, reg_rvalid}, 8'h01);
      d = reg_rdata;
   endtask : rd

   task end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (3) @(negedge clk);
      reset <= 1'b0;
      @(negedge clk);
      rd(LSF_OFS_SHORT3);
      chk(d, LSF_RST_SHORT3);
      rd(LSF_OFS_CRC);
      chk(d, LSF_RST_CRC);
      chk({6'h00, fail_safe, outputs_on}, 8'h03);
      // random patterns, all-shorted first, with a write attempt each time
      for (i = 0; i < 24; i++) begin
         d = rnd();
         {short_in_h, short_in_g} <= (i == 0) ? 6'h3f : d[5:0];
         reg_wdata <= rnd();
         wr <= 1'b1;
         req_addr <= i[0] ? LSF_OFS_CRC : LSF_OFS_SHORT3;
         @(negedge clk);
         wr <= 1'b0;
         repeat (3) @(negedge clk);
         rd(LSF_OFS_SHORT3);
         chk(d, {1'b0, short_in_h, 1'b0, short_in_g});
      end
      rd(8'h10);
      chk(d, 8'h00);
      for (i = 0; i < LSF_MEM_WORDS; i++) begin
         d = rnd();
         cfg_wr <= 1'b1;
         cfg_addr <= i[7:0];
         cfg_wdata <= d;
         mem[i] = d;
         @(negedge clk);
      end
      cfg_wr <= 1'b0;
      repeat (264) @(negedge clk);
      rd(LSF_OFS_CRC);
      chk(d, crc_exp());
      ping <= 1'b1;
      @(negedge clk);
      ping <= 1'b0;
      repeat (2) @(negedge clk);
      chk({7'h00, fail_safe}, 8'h00);
      repeat (1990) @(negedge clk);
      chk({7'h00, fail_safe}, 8'h00);
      for (n = 0; n < 30 && fail_safe !== 1'b1; n++) @(negedge clk);
      chk({6'h00, fail_safe, outputs_on}, 8'h03);
      end_of_test();
   end
endmodule : lsf_status_tb

// [verilog/lsf_crc_walk.sv]
// crc walker: crc-8 over every word of the config memory
`timescale 1ns/1ps
module lsf_crc_walk
   import lsf_pkg::*;
(
   input wire logic clk,   // 20 mhz clock
   input wire logic reset, // sync reset, active high
   lsf_crc_if.eng   cif    // request and memory port
);
   // ==========================================
   // state
   logic       busy_r, busy_nxt;   // pass in progress
   logic [7:0] addr_r, addr_nxt;   // current word
   logic [7:0] acc_r,  acc_nxt;    // running crc
   logic       done_r, done_nxt;   // result pulse

   // one byte through the crc, msb first
   function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ((x << 1) ^ LSF_CRC_POLY) : (x << 1);
      end
      return x;
   endfunction : crc_byte

   // next state: one memory word per cycle
   always_comb begin
      busy_nxt = busy_r;
      addr_nxt = addr_r;
      acc_nxt  = acc_r;
      done_nxt = 1'b0;
      if (cif.start) begin // restart wins over a pass in flight
         busy_nxt = 1'b1;
         addr_nxt = 8'h00;
         acc_nxt  = LSF_CRC_INIT;
      end else if (busy_r) begin
         acc_nxt  = crc_byte(acc_r, cif.data);
         addr_nxt = addr_r + 8'h01;
         if (addr_r == 8'(LSF_MEM_WORDS - 1)) begin // last word
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end

   // registers
   always_ff @(posedge clk) begin
      if (reset) begin
         busy_r <= 1'b0;
         addr_r <= 8'h00;
         acc_r  <= 8'h00;
         done_r <= 1'b0;
      end else begin
         busy_r <= busy_nxt;
         addr_r <= addr_nxt;
         acc_r  <= acc_nxt;
         done_r <= done_nxt;
      end
   end

   assign cif.addr = addr_r;
   assign cif.done = done_r;
   assign cif.crc  = acc_r;
endmodule : lsf_crc_walk

// [verilog/lsf_status.sv]
// status block: short fault flags, config crc result and fail-safe keeping
// ==========================================
// What this block does
// - bits 6..4 report shorts on h2..h0
// - bits 2..0 report shorts on g2..g0
// - crc of whole config memory, 8-bit read
// - lost host: enter fail-safe, keep driving
// - no host at all: run from fail-safe
`timescale 1ns/1ps
module lsf_status
   import lsf_pkg::*;
(
   input  wire logic       clk,          // 20 mhz clock
   input  wire logic       reset,        // sync reset, active high
   input  wire logic [2:0] short_in_g,   // raw short detectors g2..g0, async
   input  wire logic [2:0] short_in_h,   // raw short detectors h2..h0, async
   input  wire logic       host_activity,// pulse: valid host frame seen, same clock
   input  wire logic       cfg_wr,       // config memory write strobe
   input  wire logic [7:0] cfg_addr,     // config memory address
   input  wire logic [7:0] cfg_wdata,    // config memory write data
   input  wire logic       reg_rd,       // register read strobe
   input  wire logic       reg_wr,       // register write strobe, ignored here
   input  wire logic [7:0] reg_addr,     // register offset
   input  wire logic [7:0] reg_wdata,    // register write data, ignored here
   output logic      [7:0] reg_rdata,    // read data, registered
   output logic            reg_rvalid,   // pulse: reg_rdata valid
   output logic            fail_safe,    // level: running from fail-safe config
   output logic            outputs_on    // level: channel outputs driven
);
   // ==========================================
   // detector synchronisers
   // the detectors run off the analog side with no relation to clk, so each
   // bit passes two flops before anything reads it; the price is two cycles
   // of extra latency on every flag, far below any host polling interval
   logic [5:0] sync1_r, sync1_nxt; // first stage, read only by second
   logic [5:0] sync2_r, sync2_nxt; // second stage
   // ==========================================
   // status registers
   logic [7:0] short_r, short_nxt; // short flag register
   logic [7:0] crc_r,   crc_nxt;   // crc result register
   // ==========================================
   // config memory, kept here since only this block reads it whole
   // limitation: words never written hold unknown content, so the first crc
   // after power-up is meaningless until the image has been loaded
   logic [7:0] cfg_mem [LSF_MEM_WORDS];
   logic       dirty_r, dirty_nxt; // memory changed since last pass
   // ==========================================
   // fail-safe supervisor
   lsf_state_e state_r, state_nxt;
   logic [15:0] wdog_r, wdog_nxt;  // cycles since last host traffic, counted in normal only
   logic        fs_r, fs_nxt;
   logic        on_r, on_nxt;
   // ==========================================
   // read port
   logic [7:0] rdata_r, rdata_nxt;
   logic       rvalid_r, rvalid_nxt;

   lsf_crc_if cif ();

   lsf_crc_walk u_crc (
      .clk   (clk),
      .reset (reset),
      .cif   (cif)
   );

   // combinational memory read for the crc walker
   assign cif.data = cfg_mem[cif.addr];

   // config memory storage; no reset, content is the loaded image
   always_ff @(posedge clk) begin
      if (cfg_wr) begin
         cfg_mem[cfg_addr] <= cfg_wdata;
      end
   end

   // ==========================================
   // flags and crc next values
   always_comb begin
      sync1_nxt = {short_in_h, short_in_g};
      sync2_nxt = sync1_r;
      short_nxt = 8'h00; // reserved bits stay zero
      short_nxt[LSF_BIT_H2:LSF_BIT_H0] = sync2_r[5:3];
      short_nxt[LSF_BIT_G2:LSF_BIT_G0] = sync2_r[2:0];
      crc_nxt   = cif.done ? cif.crc : crc_r;
      // rerun after any edit; start also fires once after reset
      dirty_nxt = cfg_wr ? 1'b1 : (dirty_r ? 1'b0 : dirty_r);
   end

   assign cif.start = dirty_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
         short_r <= LSF_RST_SHORT3;
         crc_r   <= LSF_RST_CRC;
         dirty_r <= 1'b1;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         short_r <= short_nxt;
         crc_r   <= crc_nxt;
         dirty_r <= dirty_nxt;
      end
   end

   // ==========================================
   // supervisor: no host traffic within the window means fail-safe
   // the outputs stay driven in both states on purpose: losing the host must
   // never blank the lamp, it only hands control to the stored configuration
   // init lasts one cycle so outputs_on rises only once the state is known
   always_comb begin
      state_nxt = state_r;
      wdog_nxt  = wdog_r;
      case (state_r)
         LSF_ST_INIT: begin // come up in fail-safe until a host talks
            wdog_nxt  = 16'h0000;
            state_nxt = host_activity ? LSF_ST_NORMAL : LSF_ST_SAFE;
         end
         LSF_ST_NORMAL: begin
            if (host_activity) begin
               wdog_nxt = 16'h0000;
            end else if (wdog_r == 16'(LSF_WDOG_CYCLES - 1)) begin
               state_nxt = LSF_ST_SAFE;
               wdog_nxt  = 16'h0000;
            end else begin
               wdog_nxt = wdog_r + 16'h0001;
            end
         end
         LSF_ST_SAFE: begin // leave only on fresh host traffic
            if (host_activity) begin
               state_nxt = LSF_ST_NORMAL;
            end
         end
         default: state_nxt = LSF_ST_SAFE;
      endcase
      fs_nxt = (state_nxt != LSF_ST_NORMAL);
      on_nxt = (state_nxt != LSF_ST_INIT); // drive in both states
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= LSF_ST_INIT;
         wdog_r  <= 16'h0000;
         fs_r    <= 1'b0;
         on_r    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         wdog_r  <= wdog_nxt;
         fs_r    <= fs_nxt;
         on_r    <= on_nxt;
      end
   end

   // ==========================================
   // read port; writes fall through untouched
   // both status registers are read-only, so reg_wr and reg_wdata reach no
   // state at all; a write can therefore never corrupt a live flag
   // read data is held between reads so a slow host may sample it late
   always_comb begin
      rvalid_nxt = reg_rd;
      rdata_nxt  = 8'h00; // unmapped reads zero
      if (reg_addr == LSF_OFS_SHORT3) begin
         rdata_nxt = short_r & ~LSF_RSVD_MASK;
      end else if (reg_addr == LSF_OFS_CRC) begin
         rdata_nxt = crc_r;
      end
      if (!reg_rd) begin
         rdata_nxt = rdata_r;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_r  <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rdata_r  <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // ==========================================
   // every output comes straight from its flop, no logic after the register
   assign reg_rdata  = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign fail_safe  = fs_r;
   assign outputs_on = on_r;
endmodule : lsf_status
